// >>> sltpg_top.sv
// test pattern generator for the serial lanes, with apb register access
//
// The address map and register access over APB are this design's own decisions.
module sltpg_top
  import sltpg_pkg::*;
#(
  parameter int NUM_LANES = 16
) (
  input  wire logic                                 clk_sys,
  input  wire logic                                 arst_n,
  input  wire logic                                 psel,
  input  wire logic                                 penable,
  input  wire logic                                 pwrite,
  input  wire logic [7:0]                           paddr,
  input  wire logic [31:0]                          pwdata,
  output logic      [31:0]                          prdata,
  output logic                                      pready,
  output logic                                      pslverr,
  input  wire logic                                 ilasDone,
  input  wire logic                                 serdesInitDone,
  input  wire logic                                 linkDataPhaseState,
  output logic                                      linkEnable,
  output sltpg_pkg::sltpg_path_type                 pathCtrl,
  output logic      [NUM_LANES-1:0]                 lanePowerEn,
  output logic      [sltpg_pkg::RATE_W-1:0]         laneRate,
  output logic      [NUM_LANES-1:0][7:0]            laneOctet
);
  import sltpg_pkg::*;

  // apb slave state
  logic [31:0]        ctrl_r, ctrl_nxt;
  logic [31:0]        cfg0_r, cfg0_nxt;
  logic [31:0]        cfg1_r, cfg1_nxt;
  logic [31:0]        prdata_r, prdata_nxt;
  logic               pready_r, pready_nxt;
  logic               pslverr_r, pslverr_nxt;
  logic               addrHit;
  logic               wrStrobe;

  sltpg_cfg_type      cfg;
  logic [SEL_W-1:0]   sel;
  logic               linkEn;
  logic               isPrbs;
  logic               needStart;
  logic               startOk;

  // sequencer state
  sltpg_state_type    state_r, state_nxt;
  logic               clkPhase_r, clkPhase_nxt;
  logic [F_W-1:0]     octInFrame_r, octInFrame_nxt;
  logic               frameOdd_r, frameOdd_nxt;
  logic [MF_W-1:0]    mfOct_r, mfOct_nxt;

  // lane generators
  logic [NUM_LANES-1:0][PRBS_W-1:0] prbs_r, prbs_nxt;
  logic [NUM_LANES-1:0][7:0]        octet_nxt, octet_r;
  sltpg_path_type                   path_r, path_nxt;
  logic [NUM_LANES-1:0]             power_r, power_nxt;
  logic [RATE_W-1:0]                rate_r, rate_nxt;
  logic                             linkEn_r;

  // eight prbs steps per clock, first bit lands in bit 7 of the octet
  function automatic logic [PRBS_W-1:0] prbsStep(input logic [PRBS_W-1:0] s,
                                                 input logic [SEL_W-1:0]  mode);
    logic [PRBS_W-1:0] t;
    logic              nb;
    t  = s;
    nb = 1'b0;
    for (int i = 0; i < OCTET_W; i++) begin
      case (mode)
        SEL_PRBS7:  nb = t[5] ^ t[6];
        SEL_PRBS9:  nb = t[4] ^ t[8];
        SEL_PRBS15: nb = t[13] ^ t[14];
        SEL_PRBS23: nb = t[17] ^ t[22];
        default:    nb = t[27] ^ t[30];
      endcase
      t = {t[PRBS_W-2:0], nb};
    end
    return t;
  endfunction

  assign cfg.laneCount      = cfg0_r[CFG0_LANES_LSB +: LANES_W];
  assign cfg.enc64          = cfg0_r[CFG0_ENC64_BIT];
  assign cfg.sample12       = cfg0_r[CFG0_S12_BIT];
  assign cfg.laneRate       = cfg0_r[CFG0_RATE_LSB +: RATE_W];
  assign cfg.octetsPerFrame = cfg1_r[CFG1_F_LSB +: F_W];
  assign cfg.octetsPerMf    = cfg1_r[CFG1_MF_LSB +: MF_W];
  assign sel                = ctrl_r[CTRL_SEL_LSB +: SEL_W];
  assign linkEn             = ctrl_r[CTRL_LINK_EN_BIT];

  // apb register access, one wait-free access cycle after setup
  always_comb begin
    ctrl_nxt    = ctrl_r;
    cfg0_nxt    = cfg0_r;
    cfg1_nxt    = cfg1_r;
    prdata_nxt  = prdata_r;
    pslverr_nxt = pslverr_r;
    pready_nxt  = psel & ~penable;
    addrHit     = 1'b1;
    wrStrobe    = psel & penable & pready_r & pwrite;
    if (paddr == CTRL_ADDR) begin
      addrHit = 1'b1;
    end else if (paddr == CFG0_ADDR) begin
      addrHit = 1'b1;
    end else if (paddr == CFG1_ADDR) begin
      addrHit = 1'b1;
    end else if (paddr == STATUS_ADDR) begin
      addrHit = 1'b1;
    end else begin
      addrHit = 1'b0;
    end
    if (psel & ~penable) begin
      pslverr_nxt = ~addrHit;
      prdata_nxt  = 32'h0000_0000;
      if (!pwrite) begin
        if (paddr == CTRL_ADDR) begin
          prdata_nxt = ctrl_r;
        end else if (paddr == CFG0_ADDR) begin
          prdata_nxt = cfg0_r;
        end else if (paddr == CFG1_ADDR) begin
          prdata_nxt = cfg1_r;
        end else if (paddr == STATUS_ADDR) begin
          prdata_nxt[STAT_RUN_BIT]               = (state_r == ST_RUN);
          prdata_nxt[STAT_WAIT_BIT]              = (state_r == ST_WAIT);
          prdata_nxt[STAT_SEL_LSB +: SEL_W]      = sel;
        end
      end
    end
    if (wrStrobe) begin
      if (paddr == CTRL_ADDR) begin
        ctrl_nxt[CTRL_LINK_EN_BIT] = pwdata[CTRL_LINK_EN_BIT];
        // select held while the link runs so a live stream never changes mode
        if (!linkEn) begin
          ctrl_nxt[CTRL_SEL_LSB +: SEL_W] = pwdata[CTRL_SEL_LSB +: SEL_W];
        end
      end else if (paddr == CFG0_ADDR) begin
        cfg0_nxt = {20'h0_0000, pwdata[11:8], 1'b0, pwdata[6:0]};
      end else if (paddr == CFG1_ADDR) begin
        cfg1_nxt = {8'h00, pwdata[23:0]};
      end
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      ctrl_r    <= CTRL_RST;
      cfg0_r    <= CFG0_RST;
      cfg1_r    <= CFG1_RST;
      prdata_r  <= 32'h0000_0000;
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
    end else begin
      ctrl_r    <= ctrl_nxt;
      cfg0_r    <= cfg0_nxt;
      cfg1_r    <= cfg1_nxt;
      prdata_r  <= prdata_nxt;
      pready_r  <= pready_nxt;
      pslverr_r <= pslverr_nxt;
    end
  end

  assign isPrbs    = (sel >= SEL_PRBS7) && (sel <= SEL_PRBS31);
  // ramp and transport wait for the link to be ready, raw modes do not
  assign needStart = (sel == SEL_RAMP) || (sel == SEL_TRANSPORT);
  assign startOk   = cfg.enc64 ? serdesInitDone : ilasDone;

  // sequencer: idle, waiting for link start, running
  always_comb begin
    state_nxt      = state_r;
    clkPhase_nxt   = clkPhase_r;
    octInFrame_nxt = octInFrame_r;
    frameOdd_nxt   = frameOdd_r;
    mfOct_nxt      = mfOct_r;
    case (state_r)
      ST_IDLE: begin
        if (linkEn && sel != SEL_OFF) begin
          state_nxt = needStart ? ST_WAIT : ST_RUN;
        end
      end
      ST_WAIT: begin
        if (!linkEn) begin
          state_nxt = ST_IDLE;
        end else if (startOk) begin
          state_nxt = ST_RUN;
        end
      end
      ST_RUN: begin
        clkPhase_nxt = ~clkPhase_r;
        if (octInFrame_r + 8'h01 >= cfg.octetsPerFrame) begin
          octInFrame_nxt = 8'h00;
          frameOdd_nxt   = ~frameOdd_r;
        end else begin
          octInFrame_nxt = octInFrame_r + 8'h01;
        end
        // counter spans the multiframe, low byte wraps past 0xff on its own
        if (mfOct_r + 16'h0001 >= cfg.octetsPerMf) begin
          mfOct_nxt = 16'h0000;
        end else begin
          mfOct_nxt = mfOct_r + 16'h0001;
        end
        if (!linkEn) begin
          state_nxt = ST_IDLE;
        end else if (sel == SEL_TRANSPORT && !cfg.enc64 && !linkDataPhaseState) begin
          state_nxt = ST_WAIT;
        end
      end
      default: state_nxt = ST_IDLE;
    endcase
    if (state_nxt != ST_RUN) begin
      clkPhase_nxt   = 1'b0;
      octInFrame_nxt = 8'h00;
      frameOdd_nxt   = 1'b0;
      mfOct_nxt      = 16'h0000;
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      state_r      <= ST_IDLE;
      clkPhase_r   <= 1'b0;
      octInFrame_r <= 8'h00;
      frameOdd_r   <= 1'b0;
      mfOct_r      <= 16'h0000;
    end else begin
      state_r      <= state_nxt;
      clkPhase_r   <= clkPhase_nxt;
      octInFrame_r <= octInFrame_nxt;
      frameOdd_r   <= frameOdd_nxt;
      mfOct_r      <= mfOct_nxt;
    end
  end

  // per-lane pattern generation
  for (genvar l = 0; l < NUM_LANES; l++) begin : g_lane
    localparam logic [PRBS_W-1:0] SEED = PRBS_W'(l + 1);
    localparam logic [1:0]        IDX8 = 2'(l % 4);
    localparam logic [3:0]        IDX12 = 4'(l % 8);
    logic [63:0] frame12;
    logic        laneOn;
    assign frame12 = {TOP_NIBBLE - IDX12, IDX12, 4'h1,
                      TOP_NIBBLE - IDX12, IDX12, 4'h2,
                      TOP_NIBBLE - IDX12, IDX12, 4'h3,
                      TOP_NIBBLE - IDX12, IDX12, 4'h4,
                      TOP_NIBBLE - IDX12, IDX12, 4'h5,
                      TAIL_NIBBLE};
    assign laneOn  = (LANES_W'(l) < cfg.laneCount);

    always_comb begin
      prbs_nxt[l]  = prbs_r[l];
      octet_nxt[l] = 8'h00;
      if (state_r != ST_RUN) begin
        prbs_nxt[l] = SEED;
      end else if (isPrbs) begin
        prbs_nxt[l] = prbsStep(prbs_r[l], sel);
      end
      if (state_r == ST_RUN && laneOn) begin
        if (isPrbs) begin
          octet_nxt[l] = prbs_nxt[l][7:0];
        end else if (sel == SEL_CLOCK) begin
          octet_nxt[l] = clkPhase_r ? CLK_LO_OCTET : CLK_HI_OCTET;
        end else if (sel == SEL_RAMP) begin
          octet_nxt[l] = mfOct_r[7:0];
        end else if (sel == SEL_TRANSPORT) begin
          if (cfg.sample12) begin
            octet_nxt[l] = frame12[63 - 8 * octInFrame_r[2:0] -: 8];
          end else begin
            octet_nxt[l] = frameOdd_r ? ~{6'h00, IDX8} : {6'h00, IDX8};
          end
        end
      end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
        prbs_r[l]  <= SEED;
        octet_r[l] <= 8'h00;
      end else begin
        prbs_r[l]  <= prbs_nxt[l];
        octet_r[l] <= octet_nxt[l];
      end
    end
  end

  // datapath steering and serializer setup
  always_comb begin
    path_nxt.bypassLink      = isPrbs || (sel == SEL_CLOCK);
    path_nxt.bypassTransport = path_nxt.bypassLink ||
                               (sel == SEL_RAMP) ||
                               (sel == SEL_TRANSPORT);
    path_nxt.patternActive   = (state_r == ST_RUN);
    if (sel == SEL_OFF) begin
      path_nxt = '0;
    end
    // mode plays no part here: lanes and rate come from link config alone
    for (int i = 0; i < NUM_LANES; i++) begin
      power_nxt[i] = (LANES_W'(i) < cfg.laneCount);
    end
    rate_nxt = cfg.laneRate;
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      path_r   <= '0;
      power_r  <= '0;
      rate_r   <= '0;
      linkEn_r <= 1'b0;
    end else begin
      path_r   <= path_nxt;
      power_r  <= power_nxt;
      rate_r   <= rate_nxt;
      linkEn_r <= linkEn;
    end
  end

  assign prdata      = prdata_r;
  assign pready      = pready_r;
  assign pslverr     = pslverr_r;
  assign linkEnable  = linkEn_r;
  assign pathCtrl    = path_r;
  assign lanePowerEn = power_r;
  assign laneRate    = rate_r;
  assign laneOctet   = octet_r;

endmodule // sltpg_top

// >>> sltpg_pkg.sv
// constants, field layouts and types for the serial lane test pattern generator
package sltpg_pkg;

  localparam int MAX_LANES = 16;

  // register byte addresses
  localparam logic [7:0] CTRL_ADDR   = 8'h00;
  localparam logic [7:0] CFG0_ADDR   = 8'h04;
  localparam logic [7:0] CFG1_ADDR   = 8'h08;
  localparam logic [7:0] STATUS_ADDR = 8'h0c;

  // control register fields
  localparam int CTRL_LINK_EN_BIT = 0;
  localparam int CTRL_SEL_LSB     = 4;
  localparam int SEL_W            = 4;

  // link mode configuration fields
  localparam int CFG0_LANES_LSB = 0;
  localparam int LANES_W        = 5;
  localparam int CFG0_ENC64_BIT = 5;
  localparam int CFG0_S12_BIT   = 6;
  localparam int CFG0_RATE_LSB  = 8;
  localparam int RATE_W         = 4;
  localparam int CFG1_F_LSB     = 0;
  localparam int F_W            = 8;
  localparam int CFG1_MF_LSB    = 8;
  localparam int MF_W           = 16;

  // status register fields
  localparam int STAT_RUN_BIT  = 0;
  localparam int STAT_WAIT_BIT = 1;
  localparam int STAT_SEL_LSB  = 4;

  // reset values
  localparam logic [31:0] CTRL_RST  = 32'h0000_0000;
  localparam logic [31:0] CFG0_RST  = 32'h0000_0010;
  localparam logic [31:0] CFG1_RST  = 32'h0020_0001;

  // test pattern select encodings
  localparam logic [SEL_W-1:0] SEL_OFF       = 4'h0;
  localparam logic [SEL_W-1:0] SEL_PRBS7     = 4'h1;
  localparam logic [SEL_W-1:0] SEL_PRBS9     = 4'h2;
  localparam logic [SEL_W-1:0] SEL_PRBS15    = 4'h3;
  localparam logic [SEL_W-1:0] SEL_PRBS23    = 4'h4;
  localparam logic [SEL_W-1:0] SEL_PRBS31    = 4'h5;
  localparam logic [SEL_W-1:0] SEL_CLOCK     = 4'h6;
  localparam logic [SEL_W-1:0] SEL_RAMP      = 4'h7;
  localparam logic [SEL_W-1:0] SEL_TRANSPORT = 4'h8;

  localparam int PRBS_W    = 31;
  localparam int OCTET_W   = 8;
  localparam logic [7:0] CLK_HI_OCTET = 8'hff;
  localparam logic [7:0] CLK_LO_OCTET = 8'h00;
  localparam logic [3:0] TAIL_NIBBLE  = 4'h0;
  localparam logic [3:0] TOP_NIBBLE   = 4'hf;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_WAIT = 3'b010,
    ST_RUN  = 3'b100
  } sltpg_state_type;

  typedef struct packed {
    logic bypassLink;
    logic bypassTransport;
    logic patternActive;
  } sltpg_path_type;

  typedef struct packed {
    logic [LANES_W-1:0] laneCount;
    logic               enc64;
    logic               sample12;
    logic [RATE_W-1:0]  laneRate;
    logic [F_W-1:0]     octetsPerFrame;
    logic [MF_W-1:0]    octetsPerMf;
  } sltpg_cfg_type;

endpackage

// >>> sltpg_properties.sv
// concurrent checks on the pattern generator ports
module sltpg_properties
  import sltpg_pkg::*;
#(
  parameter int NUM_LANES = 16
) (
  input wire logic                        clk_sys,
  input wire logic                        arst_n,
  input wire logic                        psel,
  input wire logic                        penable,
  input wire logic                        pwrite,
  input wire logic [7:0]                  paddr,
  input wire logic [31:0]                 pwdata,
  input wire logic [31:0]                 prdata,
  input wire logic                        pready,
  input wire logic                        pslverr,
  input wire logic                        ilasDone,
  input wire logic                        serdesInitDone,
  input wire logic                        linkDataPhaseState,
  input wire logic                        linkEnable,
  input wire sltpg_pkg::sltpg_path_type   pathCtrl,
  input wire logic [NUM_LANES-1:0]        lanePowerEn,
  input wire logic [sltpg_pkg::RATE_W-1:0] laneRate,
  input wire logic [NUM_LANES-1:0][7:0]   laneOctet
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [SEL_W-1:0] sel_r;
  logic [SEL_W-1:0] sel_nxt;
  logic             wrAcc;
  assign wrAcc = psel && penable && pready && pwrite;
  // shadow of the select; writes while enabled are dropped
  always_comb begin
    sel_nxt = sel_r;
    if (wrAcc && paddr == CTRL_ADDR && !linkEnable) begin
      sel_nxt = pwdata[7:4];
    end
  end
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      sel_r <= SEL_OFF;
    end else begin
      sel_r <= sel_nxt;
    end
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!arst_n);
  chk_ready_after_setup: assert property (psel && !penable |=> pready)
    else $error("no ready after setup");
  chk_unmapped_err: assert property (psel && !penable && paddr > STATUS_ADDR |=> pslverr)
    else $error("unmapped access without error");
  chk_link_follows: assert property (wrAcc && paddr == CTRL_ADDR |->
    ##2 linkEnable == $past(pwdata[0], 2))
    else $error("link enable not taken");
  chk_rate_follows: assert property (wrAcc && paddr == CFG0_ADDR |->
    ##2 laneRate == $past(pwdata[11:8], 2))
    else $error("lane rate wrong");
  chk_power_lanes: assert property (wrAcc && paddr == CFG0_ADDR |->
    ##2 lanePowerEn == NUM_LANES'((33'h1 << $past(pwdata[4:0], 2)) - 33'h1))
    else $error("lane power mask wrong");
  chk_prbs_bypass: assert property (pathCtrl.patternActive && linkEnable &&
    sel_r inside {[SEL_PRBS7:SEL_CLOCK]} |-> pathCtrl.bypassLink && pathCtrl.bypassTransport)
    else $error("prbs or clock not bypassed");
  chk_ramp_path: assert property (pathCtrl.patternActive && sel_r == SEL_RAMP |->
    !pathCtrl.bypassLink && pathCtrl.bypassTransport)
    else $error("ramp path wrong");
  chk_clock_half: assert property (linkEnable && sel_r == SEL_CLOCK &&
    laneOctet[0] == CLK_HI_OCTET |=> laneOctet[0] == CLK_LO_OCTET)
    else $error("clock pattern wrong");
  chk_ramp_same: assert property (sel_r == SEL_RAMP && lanePowerEn[1] |->
    laneOctet[1] == laneOctet[0])
    else $error("ramp lanes differ");
  chk_ramp_step: assert property (sel_r == SEL_RAMP && laneOctet[0] != 8'h00 |->
    laneOctet[0] == $past(laneOctet[0]) + 8'h01)
    else $error("ramp step wrong");
endmodule // sltpg_properties

bind sltpg_top sltpg_properties #(.NUM_LANES(NUM_LANES)) u_chk (.clk_sys, .arst_n, .psel,
  .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .ilasDone, .serdesInitDone,
  .linkDataPhaseState, .linkEnable, .pathCtrl, .lanePowerEn, .laneRate, .laneOctet);

// >>> sltpg_rx_model.sv
// far side model: link bring-up answers and a self-syncing prbs checker on one lane
module sltpg_rx_model (
  input  wire logic       clk_sys,
  input  wire logic       arst_n,
  input  wire logic       linkEnable,
  input  wire logic [7:0] rxOctet,
  input  wire logic [4:0] tapA,
  input  wire logic [4:0] tapB,
  output logic            ilasDone,
  output logic            serdesInitDone,
  output logic            linkDataPhaseState,
  output int              errCnt,
  output int              bitCnt
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] hist;
  int          upCnt;
  // alignment takes some cycles, so early ramp or transport data would show
  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n || !linkEnable) begin
      upCnt = 0;
      hist = '0;
      bitCnt = 0;
      errCnt = 0;
    end else begin
      upCnt++;
      // no known start phase: lock on the first live octet, then check taps
      if (bitCnt > 0 || rxOctet != 8'h00) begin
        for (int i = 7; i >= 0; i--) begin
          if (bitCnt >= tapB && rxOctet[i] !== (hist[tapA-1] ^ hist[tapB-1])) errCnt++;
          hist = {hist[30:0], rxOctet[i]};
          bitCnt++;
        end
      end
    end
    ilasDone <= upCnt > 6;
    serdesInitDone <= upCnt > 3;
    // data phase opens as alignment ends, so a started pattern is never cut at once
    linkDataPhaseState <= upCnt > 6;
  end
endmodule // sltpg_rx_model

// >>> tb_sltpg_top.sv
// self-checking bench for the serial lane test pattern generator
`define CHK(g, e) begin checkCount++; if ((g) !== (e)) begin nErrors++; \
  $display("[ERR] t=%0t got=%h exp=%h", $time, g, e); end end
module tb_sltpg_top
  import sltpg_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys = 1'b0;
  logic arst_n, psel, penable, pwrite, pready, pslverr, err, diff;
  logic ilasDone, serdesInitDone, linkDataPhaseState, linkEnable;
  logic [7:0] paddr, v, mx;
  logic [31:0] pwdata, prdata, rd;
  logic [4:0] tapA, tapB;
  logic [15:0] lanePowerEn, msk;
  logic [3:0] laneRate, rate;
  logic [15:0][7:0] laneOctet;
  sltpg_path_type pathCtrl;
  int nErrors = 0, checkCount = 0, seed, errCnt, bitCnt, n, lanes;
  int ta[5] = '{6, 5, 14, 18, 28};
  int tb[5] = '{7, 9, 15, 23, 31};
  always #2 clk_sys = ~clk_sys;
  sltpg_top #(.NUM_LANES(16)) i_dut (.clk_sys, .arst_n, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .ilasDone, .serdesInitDone, .linkDataPhaseState,
    .linkEnable, .pathCtrl, .lanePowerEn, .laneRate, .laneOctet);
  sltpg_rx_model i_rx (.clk_sys, .arst_n, .linkEnable, .rxOctet(laneOctet[0]), .tapA, .tapB,
    .ilasDone, .serdesInitDone, .linkDataPhaseState, .errCnt, .bitCnt);
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, wr, a, d};
    @(posedge clk_sys);
    penable <= 1'b1;
    @(posedge clk_sys);
    while (!pready && k < 50) begin
      @(posedge clk_sys);
      k++;
    end
    if (k == 50) nErrors++;
    rd = prdata;
    err = pslverr;
    {psel, penable} <= 2'b00;
    @(posedge clk_sys);
  endtask
  // select is only changed with the link off
  task automatic runMode(input logic [3:0] s);
    apb(1'b1, CTRL_ADDR, 32'h0);
    apb(1'b1, CTRL_ADDR, {24'h0, s, 4'h0});
    apb(1'b1, CTRL_ADDR, {24'h0, s, 4'h1});
  endtask
  function automatic logic [7:0] t12(input int l, input int i);
    logic [63:0] w;
    w = '0;
    for (int k = 0; k < 5; k++) w[63-12*k -: 12] = {4'hf - 4'(l % 8), 4'(l % 8), 4'(k + 1)};
    return w[63-8*i -: 8];
  endfunction
  task automatic giveVerdict();
    $display("errors=%0d checks=%0d", nErrors, checkCount);
    if (nErrors == 0 && checkCount > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  initial begin
    #50000;
    nErrors++;
    giveVerdict();
  end
  initial begin
    seed = 32'h56d5;
    {psel, penable, pwrite, paddr, pwdata, tapA, tapB} = '0;
    arst_n = 1'b0;
    repeat (2) @(posedge clk_sys);
    arst_n <= 1'b1;
    @(posedge clk_sys);
    apb(1'b0, CFG0_ADDR, 32'h0);
    `CHK(rd, CFG0_RST)
    apb(1'b0, CFG1_ADDR, 32'h0);
    `CHK(rd, CFG1_RST)
    apb(1'b0, 8'h10, 32'h0);
    `CHK(err, 1'b1)
    // random lane setups, each under a randomly chosen mode
    repeat (4) begin
      lanes = 1 + ($unsigned($random(seed)) % 16);
      rate = 4'($random(seed));
      msk = 16'((17'h1 << lanes) - 17'h1);
      apb(1'b1, CFG0_ADDR, {20'h0, rate, 3'b000, 5'(lanes)});
      runMode(4'(1 + ($unsigned($random(seed)) % 8)));
      `CHK(lanePowerEn, msk)
      `CHK(laneRate, rate)
    end
    apb(1'b1, CFG0_ADDR, CFG0_RST);
    for (int m = 0; m < 5; m++) begin
      tapA = 5'(ta[m]);
      tapB = 5'(tb[m]);
      runMode(4'(m + 1));
      diff = 1'b0;
      repeat (40) begin
        @(posedge clk_sys);
        diff |= (laneOctet[0] !== laneOctet[1]);
      end
      `CHK(errCnt, 0)
      `CHK(bitCnt > 200, 1'b1)
      `CHK(diff, 1'b1)
    end
    apb(1'b1, CTRL_ADDR, {24'h0, SEL_CLOCK, 4'h1});
    apb(1'b0, STATUS_ADDR, 32'h0);
    `CHK(rd[7:0], {SEL_PRBS31, 4'h1})
    runMode(SEL_CLOCK);
    repeat (4) @(posedge clk_sys);
    v = laneOctet[0];
    @(posedge clk_sys);
    `CHK(laneOctet[0] ^ v, 8'hff)
    // short multiframe ends early, full one covers the whole octet range
    for (int kk = 32; kk <= 256; kk += 224) begin
      apb(1'b1, CFG1_ADDR, {8'h0, 16'(kk), 8'h01});
      runMode(SEL_RAMP);
      repeat (4) @(posedge clk_sys);
      `CHK(laneOctet[0], 8'h00)
      apb(1'b0, STATUS_ADDR, 32'h0);
      `CHK(rd[1:0], 2'b10)
      mx = 8'h00;
      repeat (kk + 40) begin
        @(posedge clk_sys);
        if (laneOctet[0] > mx) mx = laneOctet[0];
      end
      `CHK(mx, 8'(kk - 1))
    end
    apb(1'b1, CFG1_ADDR, CFG1_RST);
    runMode(SEL_TRANSPORT);
    repeat (20) @(posedge clk_sys);
    v = laneOctet[2];
    `CHK(v == 8'h02 || v == 8'hfd, 1'b1)
    `CHK(laneOctet[6], v)
    @(posedge clk_sys);
    `CHK(laneOctet[2], ~v)
    apb(1'b1, CFG0_ADDR, 32'h50);
    apb(1'b1, CFG1_ADDR, 32'h0020_0008);
    runMode(SEL_TRANSPORT);
    n = 0;
    while (laneOctet[1] === 8'h00 && n < 50) begin
      @(posedge clk_sys);
      n++;
    end
    for (int i = 0; i < 8; i++) begin
      `CHK(laneOctet[1], t12(1, i))
      `CHK(laneOctet[9], laneOctet[1])
      @(posedge clk_sys);
    end
    // 64b/66b start follows serializer init instead of alignment
    apb(1'b1, CFG1_ADDR, CFG1_RST);
    apb(1'b1, CFG0_ADDR, 32'h30);
    runMode(SEL_TRANSPORT);
    repeat (20) @(posedge clk_sys);
    v = laneOctet[3];
    `CHK(v == 8'h03 || v == 8'hfc, 1'b1)
    @(posedge clk_sys);
    `CHK(laneOctet[3], ~v)
    giveVerdict();
  end
endmodule // tb_sltpg_top
